// >>> design/csb_bank.sv
/*
  Configuration register bank reached through an index port and a
  data port. Holds the global registers, the logical device select,
  eight activate bits and the aux I/O and power management banks.
  Assumes the host request comes from logic on clk, config mode is a
  level on clk, and the three power-on resets arrive from pins.
*/
// Function
// - Index port decodes all eight bits; no aliasing of upper bits.
// - Unimplemented registers and bits ignore writes and read zero.
// - Host writes index first; data port reaches the indexed register.
// - Global registers reachable only while configuration mode is active.
// - Writing one to soft-reset bit reloads soft values; bit self-clears.
// - Index-address bit 7 enables run-mode access to aux GP ports 1/5/6, watchdog control, soft power.
// - Index-address bits 1:0 choose run-mode selection register location.
// - Logical device number picks which bank answers at per-device indices.
// - Activate write touches only the currently selected logical device.
// - Base address high byte at lower index, low byte at next.
// - Power management activate never gates system control interrupt.
// - Serial port two power bit resets only on standby-supply reset.
// - Battery-backed registers reset only on battery power-on reset.
// - Watchdog control mixes read-only and write-only bits.
// - Per-device banks only for aux I/O and power management; other devices have just an activate bit.
`timescale 1ns/1ps
`default_nettype none
`include "csb_consts.svh"

module csb_bank
  import csb_pkg::*;
(
  // Clock and hard reset
  input wire logic clk,
  input wire logic reset_n,
  // Power-on resets from pins
  input wire logic vcc_por_n,
  input wire logic vtr_por_n,
  input wire logic vbat_por_n,
  // Host index/data port
  input wire csb_host_req_t host_req,
  input wire logic cfg_mode,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  // Device side
  input wire logic pm_event,
  input wire logic wdt_status,
  output csb_activate_t activate_q,
  output logic [15:0] pm_base_q,
  output logic [7:0] pm_irq_sel_q,
  output logic [7:0] power_control_q,
  output logic [7:0] run_sel_loc_q,
  output logic [7:0] wdt_time_units_q,
  output logic [7:0] wdt_value_q,
  output logic [7:0] wdt_config_q,
  output logic [7:0] wdt_cmd_q,
  output logic soft_reset_q,
  output logic system_control_interrupt_q
);

  // Two-flop synchronisers for the pin resets
  logic [2:0] por_meta_q;
  logic [2:0] por_sync_q;
  always_ff @(posedge clk) begin
    por_meta_q <= {vbat_por_n, vtr_por_n, vcc_por_n};
    por_sync_q <= por_meta_q;
  end

  // Reset domains, all active high
  logic hard_rst;
  logic vcc_rst;
  logic vtr_rst;
  logic vbat_rst;
  assign hard_rst = !reset_n;
  assign vcc_rst = !por_sync_q[0];
  assign vtr_rst = !por_sync_q[1];
  assign vbat_rst = !por_sync_q[2];

  // Registers
  logic [7:0] index_q;
  logic [7:0] index_addr_q;
  logic [7:0] ldn_q;
  logic [7:0] spwr_en1_q;
  logic [7:0] spwr_en2_q;
  logic [7:0] spwr_st1_q;
  logic [7:0] spwr_st2_q;
  logic [7:0] gpio_pin15_q;
  logic [7:0] gpio_pin16_q;
  logic [7:0] gpio_pin17_q;
  logic [7:0] gp_irq_b_q;
  logic [7:0] gp_irq_a_q;
  logic [7:0] gp_port1_q;
  logic [7:0] gp_port5_q;
  logic [7:0] gp_port6_q;
  logic [7:0] sleep_wake_q;

  // Decode of the indexed register
  logic is_aux;
  logic is_pm;
  logic run_ok;
  logic access_ok;
  logic data_wr;
  logic data_rd;
  logic [7:0] wd;

  assign is_aux = (ldn_q == `CSB_LDN_AUX);
  assign is_pm = (ldn_q == `CSB_LDN_PWR_MGMT);
  assign wd = host_req.wdata;

  // Registers that stay reachable outside configuration mode
  always_comb begin
    run_ok = 1'b0;
    if (index_addr_q[`CSB_BIT_RUN_ENABLE] && is_aux) begin
      case (index_q)
        `CSB_IDX_GP_PORT1, `CSB_IDX_GP_PORT5, `CSB_IDX_GP_PORT6,
        `CSB_IDX_WDOG_CONTROL, `CSB_IDX_SPWR_EN1, `CSB_IDX_SPWR_EN2,
        `CSB_IDX_SPWR_ST1, `CSB_IDX_SPWR_ST2: run_ok = 1'b1;
        default: run_ok = 1'b0;
      endcase
    end
  end

  // Global range needs config mode; per-device too, except run set
  assign access_ok = cfg_mode || run_ok;
  assign data_wr = host_req.wr && host_req.data_sel && access_ok;
  assign data_rd = host_req.rd && host_req.data_sel && access_ok;

  // Index port: full eight-bit value kept, no bits dropped
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst) begin
      index_q <= `CSB_RST_ZERO;
    end else if (host_req.wr && !host_req.data_sel) begin
      index_q <= wd;
    end
  end

  // Soft reset strobe: one cycle, then clears itself
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= data_wr && (index_q == `CSB_IDX_CFG_CTRL)
        && wd[`CSB_BIT_SOFT_RESET];
    end
  end

  // Index-address control; reserved bits 6:2 never stored
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst) begin
      index_addr_q <= `CSB_RST_INDEX_ADDR;
    end else if (data_wr && index_q == `CSB_IDX_INDEX_ADDR) begin
      index_addr_q <= {wd[`CSB_BIT_RUN_ENABLE], 5'h00, wd[1:0]};
    end
  end

  // Run-mode selection register location
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst) begin
      run_sel_loc_q <= `CSB_RUN_LOC_3;
    end else begin
      case (index_addr_q[1:0])
        2'h3: run_sel_loc_q <= `CSB_RUN_LOC_3;
        2'h2: run_sel_loc_q <= `CSB_RUN_LOC_2;
        2'h1: run_sel_loc_q <= `CSB_RUN_LOC_1;
        default: run_sel_loc_q <= `CSB_RUN_LOC_0;
      endcase
    end
  end

  // Logical device select
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst) begin
      ldn_q <= `CSB_RST_ZERO;
    end else if (data_wr && index_q == `CSB_IDX_LDN) begin
      ldn_q <= wd;
    end
  end

  // Power control; serial port two bit on its own standby domain.
  // Split in two flops so each reset domain has a single writer.
  logic [4:0] pwr_low_q;
  logic pwr_serial2_q;
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst) begin
      pwr_low_q <= 5'h00;
    end else if (data_wr && index_q == `CSB_IDX_POWER_CTRL) begin
      pwr_low_q <= {wd[4:3], 2'h0, wd[0]};
    end
  end
  always_ff @(posedge clk) begin
    if (vtr_rst) begin
      pwr_serial2_q <= 1'b0;
    end else if (data_wr && index_q == `CSB_IDX_POWER_CTRL) begin
      pwr_serial2_q <= wd[`CSB_BIT_SERIAL2_PWR];
    end
  end
  // Reserved bits 7:6 read as zero
  assign power_control_q = {2'h0, pwr_serial2_q, pwr_low_q};

  // Activate bits: only the selected device's bit moves
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst || vtr_rst || soft_reset_q) begin
      activate_q <= '0;
    end else if (data_wr && index_q == `CSB_IDX_ACTIVATE) begin
      case (ldn_q)
        `CSB_LDN_FLOPPY: activate_q.floppy <= wd[0];
        `CSB_LDN_PARALLEL: activate_q.parallel <= wd[0];
        `CSB_LDN_SERIAL1: activate_q.serial1 <= wd[0];
        `CSB_LDN_SERIAL2: activate_q.serial2 <= wd[0];
        `CSB_LDN_CLOCK: activate_q.clock <= wd[0];
        `CSB_LDN_KEYBOARD: activate_q.keyboard <= wd[0];
        `CSB_LDN_AUX: activate_q.aux <= wd[0];
        `CSB_LDN_PWR_MGMT: activate_q.pwr_mgmt <= wd[0];
        default: activate_q <= activate_q;
      endcase
    end
  end

  // Power management event block base, high byte first
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst || vtr_rst || soft_reset_q) begin
      pm_base_q <= {`CSB_RST_ZERO, `CSB_RST_ZERO};
    end else if (data_wr && is_pm && index_q == `CSB_IDX_BASE_HIGH) begin
      pm_base_q[15:8] <= wd;
    end else if (data_wr && is_pm && index_q == `CSB_IDX_BASE_LOW) begin
      pm_base_q[7:0] <= wd;
    end
  end

  // Battery-backed power management registers
  always_ff @(posedge clk) begin
    if (vbat_rst) begin
      pm_irq_sel_q <= `CSB_RST_ZERO;
      sleep_wake_q <= `CSB_RST_ZERO;
    end else if (data_wr && is_pm) begin
      if (index_q == `CSB_IDX_IRQ_SEL) begin
        pm_irq_sel_q <= wd;
      end
      if (index_q == `CSB_IDX_F0) begin
        sleep_wake_q <= wd;
      end
    end
  end

  // Interrupt follows its event whatever the activate bit says
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      system_control_interrupt_q <= 1'b0;
    end else begin
      system_control_interrupt_q <= pm_event;
    end
  end

  // Battery-backed aux registers; kept through every other reset
  always_ff @(posedge clk) begin
    if (vbat_rst) begin
      spwr_en1_q <= `CSB_RST_ZERO;
      spwr_en2_q <= `CSB_RST_SPWR_EN2;
      spwr_st1_q <= `CSB_RST_ZERO;
      spwr_st2_q <= `CSB_RST_ZERO;
      gpio_pin15_q <= `CSB_RST_ZERO;
      gpio_pin16_q <= `CSB_RST_GP_ONE;
      gpio_pin17_q <= `CSB_RST_GP_ONE;
      gp_irq_b_q <= `CSB_RST_ZERO;
      gp_irq_a_q <= `CSB_RST_ZERO;
      gp_port1_q <= `CSB_RST_ZERO;
      gp_port5_q <= `CSB_RST_ZERO;
      gp_port6_q <= `CSB_RST_ZERO;
    end else if (data_wr && is_aux) begin
      case (index_q)
        `CSB_IDX_SPWR_EN1: spwr_en1_q <= wd;
        `CSB_IDX_SPWR_EN2: spwr_en2_q <= wd;
        `CSB_IDX_SPWR_ST1: spwr_st1_q <= wd;
        `CSB_IDX_SPWR_ST2: spwr_st2_q <= wd;
        `CSB_IDX_GPIO_PIN15: gpio_pin15_q <= wd;
        `CSB_IDX_GPIO_PIN16: gpio_pin16_q <= wd;
        `CSB_IDX_GPIO_PIN17: gpio_pin17_q <= wd;
        `CSB_IDX_GP_IRQ_B: gp_irq_b_q <= wd;
        `CSB_IDX_F0: gp_irq_a_q <= wd;
        `CSB_IDX_GP_PORT1: gp_port1_q <= wd;
        `CSB_IDX_GP_PORT5: gp_port5_q <= wd;
        `CSB_IDX_GP_PORT6: gp_port6_q <= wd;
        default: gpio_pin15_q <= gpio_pin15_q;
      endcase
    end
  end

  // Watchdog registers; soft reset leaves them alone
  always_ff @(posedge clk) begin
    if (hard_rst || vcc_rst || vtr_rst) begin
      wdt_time_units_q <= `CSB_RST_ZERO;
      wdt_value_q <= `CSB_RST_ZERO;
      wdt_config_q <= `CSB_RST_ZERO;
      wdt_cmd_q <= `CSB_RST_ZERO;
    end else if (data_wr && is_aux) begin
      case (index_q)
        `CSB_IDX_WDOG_UNITS: wdt_time_units_q <= wd;
        `CSB_IDX_WDOG_VALUE: wdt_value_q <= wd;
        `CSB_IDX_WDOG_CONFIG: wdt_config_q <= wd;
        // Status bit is read-only, so it is never stored
        `CSB_IDX_WDOG_CONTROL: wdt_cmd_q <= {wd[7:1], 1'b0};
        default: wdt_time_units_q <= wdt_time_units_q;
      endcase
    end
  end

  // Read mux; unmapped and reserved indices fall to zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = `CSB_RST_ZERO;
    case (index_q)
      `CSB_IDX_INDEX_ADDR: rd_mux = index_addr_q;
      `CSB_IDX_LDN: rd_mux = ldn_q;
      `CSB_IDX_POWER_CTRL: rd_mux = power_control_q;
      `CSB_IDX_ACTIVATE: begin
        case (ldn_q)
          `CSB_LDN_FLOPPY: rd_mux = {7'h00, activate_q.floppy};
          `CSB_LDN_PARALLEL: rd_mux = {7'h00, activate_q.parallel};
          `CSB_LDN_SERIAL1: rd_mux = {7'h00, activate_q.serial1};
          `CSB_LDN_SERIAL2: rd_mux = {7'h00, activate_q.serial2};
          `CSB_LDN_CLOCK: rd_mux = {7'h00, activate_q.clock};
          `CSB_LDN_KEYBOARD: rd_mux = {7'h00, activate_q.keyboard};
          `CSB_LDN_AUX: rd_mux = {7'h00, activate_q.aux};
          `CSB_LDN_PWR_MGMT: rd_mux = {7'h00, activate_q.pwr_mgmt};
          default: rd_mux = `CSB_RST_ZERO;
        endcase
      end
      default: begin
        if (is_pm) begin
          case (index_q)
            `CSB_IDX_BASE_HIGH: rd_mux = pm_base_q[15:8];
            `CSB_IDX_BASE_LOW: rd_mux = pm_base_q[7:0];
            `CSB_IDX_IRQ_SEL: rd_mux = pm_irq_sel_q;
            `CSB_IDX_F0: rd_mux = sleep_wake_q;
            default: rd_mux = `CSB_RST_ZERO;
          endcase
        end else if (is_aux) begin
          case (index_q)
            `CSB_IDX_SPWR_EN1: rd_mux = spwr_en1_q;
            `CSB_IDX_SPWR_EN2: rd_mux = spwr_en2_q;
            `CSB_IDX_SPWR_ST1: rd_mux = spwr_st1_q;
            `CSB_IDX_SPWR_ST2: rd_mux = spwr_st2_q;
            `CSB_IDX_GPIO_PIN15: rd_mux = gpio_pin15_q;
            `CSB_IDX_GPIO_PIN16: rd_mux = gpio_pin16_q;
            `CSB_IDX_GPIO_PIN17: rd_mux = gpio_pin17_q;
            `CSB_IDX_GP_IRQ_B: rd_mux = gp_irq_b_q;
            `CSB_IDX_F0: rd_mux = gp_irq_a_q;
            `CSB_IDX_WDOG_UNITS: rd_mux = wdt_time_units_q;
            `CSB_IDX_WDOG_VALUE: rd_mux = wdt_value_q;
            `CSB_IDX_WDOG_CONFIG: rd_mux = wdt_config_q;
            // Command bits read back as zero, status is live
            `CSB_IDX_WDOG_CONTROL: rd_mux = {7'h00, wdt_status};
            `CSB_IDX_GP_PORT1: rd_mux = gp_port1_q;
            `CSB_IDX_GP_PORT5: rd_mux = gp_port5_q;
            `CSB_IDX_GP_PORT6: rd_mux = gp_port6_q;
            default: rd_mux = `CSB_RST_ZERO;
          endcase
        end
      end
    endcase
  end

  // Read data: blocked data reads return zero; index-port reads return the index
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      rdata_q <= `CSB_RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host_req.rd;
      if (data_rd) begin
        rdata_q <= rd_mux;
      end else if (host_req.rd && !host_req.data_sel) begin
        rdata_q <= index_q;
      end else if (host_req.rd) begin
        rdata_q <= `CSB_RST_ZERO;
      end
    end
  end

endmodule
`default_nettype wire

// >>> pkg/csb_consts.svh
/*
  Named offsets, logical device numbers and reset values for the
  configuration register bank. Included by the bank's design file.
*/
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

// Global register indices
`define CSB_IDX_CFG_CTRL 8'h02
`define CSB_IDX_INDEX_ADDR 8'h03
`define CSB_IDX_LDN 8'h07
`define CSB_IDX_POWER_CTRL 8'h22
`define CSB_IDX_GLOBAL_TOP 8'h2f

// Per-device register indices
`define CSB_IDX_ACTIVATE 8'h30
`define CSB_IDX_BASE_HIGH 8'h60
`define CSB_IDX_BASE_LOW 8'h61
`define CSB_IDX_IRQ_SEL 8'h70
`define CSB_IDX_SPWR_EN1 8'hb0
`define CSB_IDX_SPWR_EN2 8'hb1
`define CSB_IDX_SPWR_ST1 8'hb2
`define CSB_IDX_SPWR_ST2 8'hb3
`define CSB_IDX_GPIO_PIN15 8'he5
`define CSB_IDX_GPIO_PIN16 8'he6
`define CSB_IDX_GPIO_PIN17 8'he7
`define CSB_IDX_GP_IRQ_B 8'hef
`define CSB_IDX_F0 8'hf0
`define CSB_IDX_WDOG_UNITS 8'hf1
`define CSB_IDX_WDOG_VALUE 8'hf2
`define CSB_IDX_WDOG_CONFIG 8'hf3
`define CSB_IDX_WDOG_CONTROL 8'hf4
`define CSB_IDX_GP_PORT1 8'hf6
`define CSB_IDX_GP_PORT5 8'hf9
`define CSB_IDX_GP_PORT6 8'hfa

// Logical device numbers
`define CSB_LDN_FLOPPY 8'h00
`define CSB_LDN_PARALLEL 8'h03
`define CSB_LDN_SERIAL1 8'h04
`define CSB_LDN_SERIAL2 8'h05
`define CSB_LDN_CLOCK 8'h06
`define CSB_LDN_KEYBOARD 8'h07
`define CSB_LDN_AUX 8'h08
`define CSB_LDN_PWR_MGMT 8'h0a

// Reset values
`define CSB_RST_ZERO 8'h00
`define CSB_RST_INDEX_ADDR 8'h03
`define CSB_RST_GP_ONE 8'h01
`define CSB_RST_SPWR_EN2 8'h80

// Field positions
`define CSB_BIT_SOFT_RESET 0
`define CSB_BIT_RUN_ENABLE 7
`define CSB_BIT_SERIAL2_PWR 5
`define CSB_BIT_WDT_STATUS 0

// Run-mode selection register locations
`define CSB_RUN_LOC_3 8'hea
`define CSB_RUN_LOC_2 8'he4
`define CSB_RUN_LOC_1 8'he2
`define CSB_RUN_LOC_0 8'he0

`endif

// >>> pkg/csb_pkg.sv
/*
  Types for the configuration register bank: the host request and
  the per-device activate vector. Needs nothing else.
*/
package csb_pkg;

  // One host access on the index/data port pair
  typedef struct packed {
    logic wr;
    logic rd;
    logic data_sel;
    logic [7:0] wdata;
  } csb_host_req_t;

  // Activate bit of each of the eight logical devices
  typedef struct packed {
    logic pwr_mgmt;
    logic aux;
    logic keyboard;
    logic clock;
    logic serial2;
    logic serial1;
    logic parallel;
    logic floppy;
  } csb_activate_t;

endpackage

// >>> sim/csb_bank_chk.sv
/*
  Port checker for the configuration register bank.
  Assumes it is bound to csb_bank and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_bank_chk
  import csb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host port
  input wire csb_host_req_t host_req,
  input wire logic cfg_mode,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  // Device side
  input wire logic pm_event,
  input wire csb_activate_t activate_q,
  input wire logic [15:0] pm_base_q,
  input wire logic [7:0] run_sel_loc_q,
  input wire logic [7:0] wdt_cmd_q,
  input wire logic soft_reset_q,
  input wire logic system_control_interrupt_q
);
  logic [7:0] idx_q;
  logic [7:0] ldn_q;
  logic dwr;
  logic drd;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Data port access taken in config mode
  assign dwr = host_req.wr && host_req.data_sel && cfg_mode;
  assign drd = host_req.rd && host_req.data_sel && cfg_mode;
  // Shadow of index; power-on resets are not watched here
  always_ff @(posedge clk) begin
    if (!reset_n) idx_q <= 8'h00;
    else if (host_req.wr && !host_req.data_sel) idx_q <= host_req.wdata;
  end
  // Shadow of the device select
  always_ff @(posedge clk) begin
    if (!reset_n) ldn_q <= 8'h00;
    else if (dwr && idx_q == 8'h07) ldn_q <= host_req.wdata;
  end
  AST_RD_ANSWER: assert property (host_req.rd |=> rvalid_q)
    else $error("read without answer");
  AST_NO_SPURIOUS: assert property (!host_req.rd |=> !rvalid_q)
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (!rvalid_q |-> $stable(rdata_q))
    else $error("read data moved");
  AST_GLOBAL_GATED: assert property ((host_req.rd && host_req.data_sel && !cfg_mode
    && idx_q <= 8'h2f) |=> rdata_q == 8'h00) else $error("global read leaked");
  AST_RESERVED_ZERO: assert property ((drd && idx_q inside {[8'h08:8'h1f]})
    |=> rdata_q == 8'h00) else $error("reserved read not zero");
  AST_SOFT_PULSE: assert property ((dwr && idx_q == 8'h02 && host_req.wdata[0])
    |=> soft_reset_q ##1 !soft_reset_q) else $error("soft reset pulse wrong");
  AST_SOFT_CLEAR: assert property (soft_reset_q |=>
    (activate_q == 8'h00 && pm_base_q == 16'h0000)) else $error("soft values not loaded");
  AST_BASE_HIGH: assert property ((dwr && ldn_q == 8'h0a && idx_q == 8'h60)
    |=> pm_base_q[15:8] == $past(host_req.wdata)) else $error("base high byte wrong");
  AST_SYS_INT: assert property ((pm_event && !activate_q.pwr_mgmt)
    |=> system_control_interrupt_q) else $error("interrupt gated");
  AST_WDT_RO_BIT: assert property (wdt_cmd_q[0] == 1'b0)
    else $error("watchdog command bit 0 set");
  AST_RUN_LOC: assert property (run_sel_loc_q inside {8'hea, 8'he4, 8'he2, 8'he0})
    else $error("run location illegal");
  // Main scenarios reached
  CV_SOFT: cover property (soft_reset_q);
  CV_RUN_RD: cover property (host_req.rd && !cfg_mode);
  CV_SYS_INT: cover property (system_control_interrupt_q && !activate_q.pwr_mgmt);
endmodule
`default_nettype wire

// >>> sim/csb_host_model.sv
/*
  Host processor model: index/data port cycles on the bank.
  Assumes the bank answers a read one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none
module csb_host_model
  import csb_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request and answer
  output csb_host_req_t host_req,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q
);
  initial host_req = '0;
  // One request per edge, changed just after the edge
  task automatic put(input logic w, input logic sel, input logic [7:0] d);
    @(posedge clk);
    host_req <= {w, !w, sel, d};
  endtask
  // Idle data inverted so a stale byte never passes for live
  task automatic idle();
    @(posedge clk);
    host_req <= {3'b000, ~host_req.wdata};
  endtask
  // Index first, then data, back to back
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    put(1'b1, 1'b0, idx);
    put(1'b1, 1'b1, d);
    idle();
    // One more edge so registered results have settled for the caller
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic v);
    put(1'b1, 1'b0, idx);
    put(1'b0, 1'b1, ~idx);
    idle();
    @(posedge clk);
    d = rdata_q;
    v = rvalid_q;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_config_space_index_data_bank.sv
/*
  Self-checking bench for the configuration register bank.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_config_space_index_data_bank;
  import csb_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  // Power-on resets start asserted so battery and standby flops get values
  logic vcc_por_n = 1'b0;
  logic vtr_por_n = 1'b0;
  logic vbat_por_n = 1'b0;
  logic cfg_mode = 1'b1;
  logic pm_event = 1'b0;
  logic wdt_status = 1'b0;
  csb_host_req_t host_req;
  csb_activate_t activate_q;
  logic [15:0] pm_base_q;
  logic [7:0] rdata_q, pm_irq_sel_q, power_control_q, run_sel_loc_q, wdt_cmd_q;
  logic [7:0] wdt_time_units_q, wdt_value_q, wdt_config_q;
  logic rvalid_q, soft_reset_q, sys_int_q;
  int errors = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  // Host on the index/data port
  csb_host_model i_host (.clk(clk), .host_req(host_req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q));
  csb_bank i_dut (.clk(clk), .reset_n(reset_n), .vcc_por_n(vcc_por_n),
    .vtr_por_n(vtr_por_n), .vbat_por_n(vbat_por_n), .host_req(host_req),
    .cfg_mode(cfg_mode), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .pm_event(pm_event),
    .wdt_status(wdt_status), .activate_q(activate_q), .pm_base_q(pm_base_q),
    .pm_irq_sel_q(pm_irq_sel_q), .power_control_q(power_control_q),
    .run_sel_loc_q(run_sel_loc_q), .wdt_time_units_q(wdt_time_units_q),
    .wdt_value_q(wdt_value_q), .wdt_config_q(wdt_config_q),
    .wdt_cmd_q(wdt_cmd_q), .soft_reset_q(soft_reset_q),
    .system_control_interrupt_q(sys_int_q));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read through the data port and judge answer and value
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_host.rd(idx, d, v);
    chk("rvalid", 16'h0001, {15'h0000, v});
    chk($sformatf("reg %h", idx), {8'h00, exp}, {8'h00, d});
  endtask
  task automatic t_basics();
    logic [7:0] loc [4] = '{8'he0, 8'he2, 8'he4, 8'hea};
    logic [7:0] rsv [5] = '{8'h00, 8'h04, 8'h06, 8'h08, 8'h1f};
    rchk(8'h03, 8'h03);
    chk("run loc", 16'h00ea, {8'h00, run_sel_loc_q});
    i_host.wr(8'h07, 8'h08);
    rchk(8'he6, 8'h01);
    i_host.wr(8'h07, 8'h0a);
    i_host.wr(8'h87, 8'h55);
    rchk(8'h07, 8'h0a);
    rchk(8'h87, 8'h00);
    rchk(8'h02, 8'h00);
    foreach (rsv[k]) begin
      i_host.wr(rsv[k], 8'hff);
      rchk(rsv[k], 8'h00);
    end
    for (int v = 0; v < 4; v++) begin
      i_host.wr(8'h03, {6'h1f, v[1:0]});
      rchk(8'h03, {6'h00, v[1:0]});
      chk("run loc", {8'h00, loc[v]}, {8'h00, run_sel_loc_q});
    end
  endtask
  task automatic t_activate();
    logic [7:0] ldn [8] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};
    logic [7:0] exp = 8'h00;
    foreach (ldn[k]) begin
      i_host.wr(8'h07, ldn[k]);
      i_host.wr(8'h30, 8'h01);
      exp[k] = 1'b1;
      chk("activate", {8'h00, exp}, {8'h00, activate_q});
    end
    i_host.wr(8'h07, 8'h04);
    i_host.wr(8'h30, 8'h00);
    chk("activate", 16'h00fb, {8'h00, activate_q});
  endtask
  task automatic t_base_soft();
    i_host.wr(8'h07, 8'h0a);
    i_host.wr(8'h61, 8'h34);
    i_host.wr(8'h60, 8'h12);
    chk("base", 16'h1234, pm_base_q);
    rchk(8'h60, 8'h12);
    i_host.wr(8'h70, 8'h05);
    i_host.wr(8'h02, 8'h01);
    step(2);
    chk("activate", 16'h0000, {8'h00, activate_q});
    chk("base", 16'h0000, pm_base_q);
    chk("irq sel", 16'h0005, {8'h00, pm_irq_sel_q});
    chk("soft", 16'h0000, {15'h0000, soft_reset_q});
    pm_event <= 1'b1;
    step(3);
    chk("sys int", 16'h0001, {15'h0000, sys_int_q});
    pm_event <= 1'b0;
  endtask
  task automatic t_gate_wdt();
    i_host.wr(8'h07, 8'h08);
    i_host.wr(8'hf6, 8'h5a);
    i_host.wr(8'hf1, 8'h3c);
    i_host.wr(8'hf2, 8'h5d);
    i_host.wr(8'hf3, 8'h6e);
    chk("watchdog_time_units", 16'h003c, {8'h00, wdt_time_units_q});
    chk("wdt value", 16'h005d, {8'h00, wdt_value_q});
    chk("wdt config", 16'h006e, {8'h00, wdt_config_q});
    cfg_mode <= 1'b0;
    i_host.wr(8'hf6, 8'ha5);
    rchk(8'hf6, 8'h00);
    rchk(8'h07, 8'h00);
    cfg_mode <= 1'b1;
    rchk(8'hf6, 8'h5a);
    i_host.wr(8'h03, 8'h83);
    cfg_mode <= 1'b0;
    i_host.wr(8'hf6, 8'ha5);
    i_host.wr(8'h07, 8'h0a);
    rchk(8'hf6, 8'ha5);
    rchk(8'hf1, 8'h00);
    cfg_mode <= 1'b1;
    rchk(8'h07, 8'h08);
    rchk(8'hf1, 8'h3c);
    i_host.wr(8'hf4, 8'hff);
    chk("wdt cmd", 16'h00fe, {8'h00, wdt_cmd_q});
    wdt_status <= 1'b1;
    rchk(8'hf4, 8'h01);
  endtask
  task automatic t_resets();
    i_host.wr(8'h22, 8'hff);
    chk("power", 16'h0039, {8'h00, power_control_q});
    reset_n <= 1'b0;
    step(3);
    reset_n <= 1'b1;
    step(2);
    chk("power", 16'h0020, {8'h00, power_control_q});
    chk("irq sel", 16'h0005, {8'h00, pm_irq_sel_q});
    chk("watchdog_time_units", 16'h0000, {8'h00, wdt_time_units_q});
    vtr_por_n <= 1'b0;
    step(4);
    vtr_por_n <= 1'b1;
    step(4);
    chk("power", 16'h0000, {8'h00, power_control_q});
    vbat_por_n <= 1'b0;
    step(4);
    vbat_por_n <= 1'b1;
    step(4);
    chk("irq sel", 16'h0000, {8'h00, pm_irq_sel_q});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  // Power-on resets released early so their synchronisers settle first
  initial begin
    step(8);
    vcc_por_n <= 1'b1;
    vtr_por_n <= 1'b1;
    vbat_por_n <= 1'b1;
    step(4);
    reset_n <= 1'b1;
    t_basics();
    t_activate();
    t_base_soft();
    t_gate_wdt();
    t_resets();
    final_report();
  end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #500000;
    errors++;
    final_report();
  end
endmodule
bind csb_bank csb_bank_chk i_chk (.clk(clk), .reset_n(reset_n), .host_req(host_req),
  .cfg_mode(cfg_mode), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .pm_event(pm_event),
  .activate_q(activate_q), .pm_base_q(pm_base_q), .run_sel_loc_q(run_sel_loc_q),
  .wdt_cmd_q(wdt_cmd_q), .soft_reset_q(soft_reset_q),
  .system_control_interrupt_q(system_control_interrupt_q));
`default_nettype wire
